// >>> inc/pia_pkg.sv
// Constants and types of the paged register access slave.
`default_nettype none
package pia_pkg;

  // ---------------------------------------------------------------
  // Slave address
  // ---------------------------------------------------------------
  localparam logic [2:0] PIA_ADDR_HI = 3'h5;
  localparam logic [3:0] PIA_ADDR_LO_GND = 4'h0;
  localparam logic [3:0] PIA_ADDR_LO_VCC = 4'hf;
  localparam logic [3:0] PIA_ADDR_LO_SCL = 4'h5;
  localparam logic [3:0] PIA_ADDR_LO_SDA = 4'ha;
  localparam logic [1:0] PIA_STRAP_GND = 2'h0;
  localparam logic [1:0] PIA_STRAP_VCC = 2'h1;
  localparam logic [1:0] PIA_STRAP_SCL = 2'h2;
  localparam logic [1:0] PIA_STRAP_SDA = 2'h3;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] PIA_REG_IMASK = 8'hf0;
  localparam logic [7:0] PIA_REG_ISTAT = 8'hf1;
  localparam logic [7:0] PIA_REG_PAGE = 8'hfd;
  localparam logic [7:0] PIA_REG_UNLOCK = 8'hfe;
  localparam logic [7:0] PIA_UNLOCK_KEY = 8'hc5;
  localparam logic [7:0] PIA_KEY_RESET = 8'h00;
  localparam logic [7:0] PIA_PAGE_MAX = 8'h03;
  localparam logic [7:0] PIA_OPEN_FIRST = 8'h18;
  localparam logic [7:0] PIA_OPEN_LAST = 8'h2d;
  localparam logic [7:0] PIA_SHORT_FIRST = 8'h30;
  localparam logic [7:0] PIA_SHORT_LAST = 8'h45;
  localparam logic [7:0] PIA_RESET_REG = 8'h11;
  localparam logic [1:0] PIA_PAGE_LED_CONTROL = 2'h0;
  localparam logic [1:0] PIA_PAGE_PWM = 2'h1;
  localparam logic [1:0] PIA_PAGE_BREATH_SELECT = 2'h2;
  localparam logic [1:0] PIA_PAGE_FUNCTION = 2'h3;
  localparam logic [3:0] PIA_BITS_PER_BYTE = 4'h8;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int PIA_CLK_NS = 25;
  localparam int PIA_AUTO_CLR_NS = 8000000;
  localparam int PIA_AUTO_CLR_CYC =
    (PIA_AUTO_CLR_NS + PIA_CLK_NS - 1) / PIA_CLK_NS;
  localparam int PIA_LOWCNT_W = 20;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [8:0] {
    PIA_S_IDLE = 9'h001,
    PIA_S_ADDR = 9'h002,
    PIA_S_AACK = 9'h004,
    PIA_S_REG = 9'h008,
    PIA_S_RGACK = 9'h010,
    PIA_S_WDATA = 9'h020,
    PIA_S_WACK = 9'h040,
    PIA_S_RDATA = 9'h080,
    PIA_S_RACK = 9'h100
  } pia_state_t;

  typedef struct packed {
    logic irq_auto_clear_en;
    logic irq_breath_done_en;
    logic irq_short_en;
    logic irq_open_en;
  } pia_mask_t;

  typedef struct packed {
    logic breath_pattern3_done;
    logic breath_pattern2_done;
    logic breath_pattern1_done;
    logic short_seen;
    logic open_seen;
  } pia_status_t;

  typedef struct packed {
    logic [2:0] breath_done;
    logic dot_short;
    logic dot_open;
  } pia_events_t;

  typedef struct packed {
    logic valid;
    logic [1:0] page;
    logic [7:0] addr;
    logic [7:0] data;
  } pia_wr_t;

  typedef struct packed {
    pia_state_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic rd;
    logic ack_ok;
    logic oe;
    logic [7:0] ptr;
    logic [1:0] page;
    logic [7:0] page_lock_key;
    pia_mask_t mask;
    pia_status_t status;
    logic [PIA_LOWCNT_W-1:0] lowcnt;
    logic scl_q;
    logic sda_q;
    pia_wr_t wr;
  } pia_regs_t;

endpackage
`default_nettype wire

// >>> verification/pia_host_model.sv
// Bus master model that drives frames onto the two-wire bus.
`timescale 1ns/10ps
`default_nettype none
module pia_host_model (
  input wire logic ref_clk,
  input wire logic sda_oe,
  input wire logic sda_out,
  output logic scl,
  output logic sda
);
  logic m_low = 1'b0;

  initial scl = 1'b1;

  // ---------------------------------------------------------------
  // Wire and bit timing
  // ---------------------------------------------------------------
  // Open-drain line with a pull-up, so a released line reads high; the
  // slave's drive level only counts while its enable is set.
  assign sda = !m_low && (!sda_oe || sda_out);

  task automatic cyc(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  // Data only moves while the clock is low; it is read late in the high
  // phase so the slave's answer has long settled.
  task automatic bit_io(input logic b, output logic s);
    m_low = !b;
    cyc(2);
    scl = 1'b1;
    cyc(3);
    s = sda;
    cyc(1);
    scl = 1'b0;
    cyc(2);
  endtask

  task automatic start();
    m_low = 1'b0;
    cyc(2);
    scl = 1'b1;
    cyc(2);
    m_low = 1'b1;
    cyc(2);
    scl = 1'b0;
    cyc(2);
  endtask

  task automatic stop();
    m_low = 1'b1;
    cyc(2);
    scl = 1'b1;
    cyc(2);
    m_low = 1'b0;
    cyc(4);
  endtask

  task automatic send_byte(input logic [7:0] b, output logic nak);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, nak);
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask
endmodule // pia_host_model
`default_nettype wire

// >>> verification/tb_paged_i2c_register_access.sv
// Self-checking bench for the paged register access slave.
`timescale 1ns/10ps
`default_nettype none
module tb_paged_i2c_register_access import pia_pkg::*;;
  localparam int AC = 50;
  logic ref_clk, sys_rst, scl, sda, sda_oe, sda_drv, interrupt_out_n, nak;
  logic [1:0] addr_strap, page_sel;
  logic [7:0] ext_rdata, rd_addr;
  logic [6:0] dev;
  logic [3:0] lo[4] = '{PIA_ADDR_LO_GND, PIA_ADDR_LO_VCC,
                        PIA_ADDR_LO_SCL, PIA_ADDR_LO_SDA};
  pia_events_t events;
  pia_wr_t reg_wr;
  pia_wr_t wq[$];
  int err_count, checks, cycles;

  function automatic logic [7:0] xr(logic [7:0] a, logic [1:0] p);
    return a ^ {6'h00, p} ^ 8'h3c;
  endfunction

  assign ext_rdata = xr(rd_addr, page_sel);

  pia_i2c_slave #(.AUTO_CLR_CYCLES(AC)) dut (.ref_clk(ref_clk),
    .sys_rst(sys_rst), .scl_in(scl), .sda_in(sda), .sda_out(sda_drv),
    .sda_oe(sda_oe), .addr_strap(addr_strap), .events(events),
    .ext_rdata(ext_rdata), .rd_addr(rd_addr), .page_sel(page_sel),
    .reg_wr(reg_wr), .interrupt_out_n(interrupt_out_n));

  pia_host_model host (.ref_clk(ref_clk), .sda_oe(sda_oe), .scl(scl),
    .sda(sda), .sda_out(sda_drv));

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Watchdog and capture of paged writes leaving the block.
  always @(posedge ref_clk) begin
    cycles++;
    if (reg_wr.valid === 1'b1) wq.push_back(reg_wr);
    if (cycles == 30000) begin
      err_count++;
      test_done();
    end
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    if (err_count == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string w, input logic [18:0] e,
                     input logic [18:0] g);
    checks++;
    if (g !== e) begin
      $display("wrong value %s expected %h seen %h", w, e, g);
      err_count++;
    end
  endtask

  task automatic wr(input logic [7:0] ra, input logic [7:0] d[$]);
    logic k;
    host.start();
    host.send_byte({dev, 1'b0}, k);
    chk("address ack", 19'h0, {18'h0, k});
    host.send_byte(ra, k);
    chk("register ack", 19'h0, {18'h0, k});
    foreach (d[i]) begin
      host.send_byte(d[i], k);
      chk("data ack", 19'h0, {18'h0, k});
    end
    host.stop();
  endtask

  task automatic rd(input logic [7:0] ra, input logic [7:0] e[$]);
    logic k;
    logic [7:0] v;
    host.start();
    host.send_byte({dev, 1'b0}, k);
    host.send_byte(ra, k);
    host.start();
    host.send_byte({dev, 1'b1}, k);
    chk("read ack", 19'h0, {18'h0, k});
    foreach (e[i]) begin
      host.recv_byte(i == e.size() - 1, v);
      chk("read data", {11'h0, e[i]}, {11'h0, v});
    end
    host.stop();
  endtask

  task automatic page(input logic [7:0] c);
    wr(PIA_REG_UNLOCK, '{PIA_UNLOCK_KEY});
    wr(PIA_REG_PAGE, '{c});
  endtask

  task automatic fire(input logic [4:0] e);
    events = pia_events_t'(e);
    @(negedge ref_clk);
    events = '0;
    repeat (3) @(negedge ref_clk);
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'b1;
    addr_strap = PIA_STRAP_GND;
    events = '0;
    dev = {PIA_ADDR_HI, PIA_ADDR_LO_GND};
    repeat (6) @(negedge ref_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge ref_clk);
    chk("page", 19'h0, {17'h0, page_sel});
    chk("irq out", 19'h1, {18'h0, interrupt_out_n});
    fire(5'h1f);
    chk("mask at reset", 19'h1, {18'h0, interrupt_out_n});
    rd(PIA_REG_UNLOCK, '{8'h00});
    rd(PIA_REG_ISTAT, '{8'h00});
    for (int k = 0; k < 4; k++) begin
      addr_strap = 2'(k);
      dev = {PIA_ADDR_HI, lo[k]};
      wr(PIA_REG_UNLOCK, '{8'h30 + 8'(k)});
      rd(PIA_REG_UNLOCK, '{8'h30 + 8'(k)});
    end
    host.start();
    host.send_byte({PIA_ADDR_HI, PIA_ADDR_LO_GND, 1'b0}, nak);
    host.stop();
    chk("foreign address", 19'h1, {18'h0, nak});
    wr(PIA_REG_PAGE, '{8'h03});
    chk("locked page", 19'h0, {17'h0, page_sel});
    wr(PIA_REG_UNLOCK, '{PIA_UNLOCK_KEY});
    rd(PIA_REG_UNLOCK, '{PIA_UNLOCK_KEY});
    wr(PIA_REG_PAGE, '{8'h02});
    chk("page once", 19'h2, {17'h0, page_sel});
    rd(PIA_REG_UNLOCK, '{8'h00});
    wr(PIA_REG_PAGE, '{8'h01});
    chk("relocked", 19'h2, {17'h0, page_sel});
    for (int k = 0; k < 4; k++) begin
      page(8'(k));
      chk("page code", 19'(k), {17'h0, page_sel});
    end
    page(8'h07);
    chk("reserved code", 19'h3, {17'h0, page_sel});
    page(8'h01);
    wq.delete();
    wr(8'h10, '{8'ha1, 8'ha2, 8'ha3});
    chk("write count", 19'h3, 19'(wq.size()));
    for (int k = 0; k < 3; k++)
      chk("paged write", pia_wr_t'{1'b1, 2'h1, 8'h10 + 8'(k),
          8'ha1 + 8'(k)}, wq[k]);
    page(8'h00);
    wq.delete();
    wr(8'h2d, '{8'h5a, 8'h5b});
    chk("skip count", 19'h1, 19'(wq.size()));
    chk("skip write", pia_wr_t'{1'b1, 2'h0, 8'h2e, 8'h5b}, wq[0]);
    rd(8'h2c, '{xr(8'h2c, 2'h0), xr(8'h2d, 2'h0), 8'h00});
    rd(8'h30, '{xr(8'h30, 2'h0)});
    rd(8'h10, '{8'h00});
    rd(PIA_REG_IMASK, '{8'h00});
    page(8'h03);
    rd(8'h11, '{xr(8'h11, 2'h3)});
    page(8'h01);
    rd(8'h18, '{8'h00});
    wr(PIA_REG_IMASK, '{8'h03});
    fire(5'h1c);
    chk("masked event", 19'h1, {18'h0, interrupt_out_n});
    fire(5'h01);
    chk("open event", 19'h0, {18'h0, interrupt_out_n});
    rd(PIA_REG_ISTAT, '{8'h01});
    chk("cleared", 19'h1, {18'h0, interrupt_out_n});
    wr(PIA_REG_IMASK, '{8'h04});
    fire(5'h1e);
    rd(PIA_REG_ISTAT, '{8'h1c});
    wr(PIA_REG_ISTAT, '{8'hff});
    rd(PIA_REG_ISTAT, '{8'h00});
    wr(PIA_REG_IMASK, '{8'h0a});
    fire(5'h02);
    repeat (AC - 10) @(negedge ref_clk);
    chk("early clear", 19'h0, {18'h0, interrupt_out_n});
    repeat (20) @(negedge ref_clk);
    chk("auto clear", 19'h1, {18'h0, interrupt_out_n});
    wr(PIA_REG_IMASK, '{8'h02});
    fire(5'h02);
    repeat (AC + 10) @(negedge ref_clk);
    chk("no auto clear", 19'h0, {18'h0, interrupt_out_n});
    rd(PIA_REG_ISTAT, '{8'h02});
    test_done();
  end
endmodule // tb_paged_i2c_register_access
`default_nettype wire

// >>> verilog/pia_i2c_slave.sv
// Paged register access slave with lock, interrupt mask and status.
//
// Function
// - Address is 101 plus four bits chosen by the address strap.
// - Bit after the address selects write (0) or read (1).
// - Data is sampled while clock is high; idle data line is high.
// - Data falling while clock high starts a transfer and address compare.
// - Data rising while clock high ends the transfer.
// - Device pulls data low during the ninth clock when address matched.
// - Register address byte follows the address and is acknowledged.
// - Every written data byte is received MSB first and acknowledged.
// - The register pointer advances by one with each data acknowledge.
// - Only unlock, status, page-zero open/short, page-three reset read back.
// - Read is write of address, repeated start, address with read bit.
// - Page codes 0 to 3 select the four pages; others are reserved.
// - Page selector holds page zero after reset.
// - Page selector ignores writes until unlocked.
// - Key c5 allows one page write, then the lock returns to zero.
// - Lock register reads back and resets to zero.
// - Mask holds auto clear in bit 3 and event enables in bits 2..0.
// - With auto clear set, status clears after output low over 8 ms.
// - Each enable lets its event raise the interrupt; zero suppresses it.
// - Status shows three breath finishes, short and open, reset zero.
`timescale 1ns/10ps
`default_nettype none
module pia_i2c_slave
  import pia_pkg::*;
#(
  parameter int unsigned AUTO_CLR_CYCLES = PIA_AUTO_CLR_CYC
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [1:0] addr_strap,
  input wire pia_events_t events,
  input wire logic [7:0] ext_rdata,
  output logic [7:0] rd_addr,
  output logic [1:0] page_sel,
  output pia_wr_t reg_wr,
  output logic interrupt_out_n
);

  // ---------------------------------------------------------------
  // Input synchronisation and bus conditions
  // ---------------------------------------------------------------
  logic scl_s;
  logic sda_s;
  logic [1:0] strap_s;
  pia_regs_t q_ff;
  pia_regs_t nxt_q;

  pia_sync #(
    .W(4)
  ) u_sync (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .async_in({scl_in, sda_in, addr_strap}),
    .sync_out({scl_s, sda_s, strap_s})
  );

  logic scl_rise;
  logic scl_fall;
  logic start;
  logic stop;
  logic [3:0] addr_lo;

  assign scl_rise = scl_s & ~q_ff.scl_q;
  assign scl_fall = ~scl_s & q_ff.scl_q;
  assign start = scl_s & q_ff.scl_q & q_ff.sda_q & ~sda_s;
  assign stop = scl_s & q_ff.scl_q & ~q_ff.sda_q & sda_s;

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic [3:0] strap_addr(input logic [1:0] s);
    case (s)
      PIA_STRAP_GND: strap_addr = PIA_ADDR_LO_GND;
      PIA_STRAP_VCC: strap_addr = PIA_ADDR_LO_VCC;
      PIA_STRAP_SCL: strap_addr = PIA_ADDR_LO_SCL;
      default: strap_addr = PIA_ADDR_LO_SDA;
    endcase
  endfunction

  function automatic logic ext_rd(input logic [1:0] pg,
                                  input logic [7:0] a);
    ext_rd = (pg == PIA_PAGE_LED_CONTROL &&
              ((a >= PIA_OPEN_FIRST && a <= PIA_OPEN_LAST) ||
               (a >= PIA_SHORT_FIRST && a <= PIA_SHORT_LAST))) ||
             (pg == PIA_PAGE_FUNCTION && a == PIA_RESET_REG);
  endfunction

  function automatic logic [7:0] rd_byte(input pia_regs_t r,
                                         input logic [7:0] ext);
    if (r.ptr == PIA_REG_UNLOCK) begin
      rd_byte = r.page_lock_key;
    end else if (r.ptr == PIA_REG_ISTAT) begin
      rd_byte = {3'h0, r.status};
    end else if (ext_rd(r.page, r.ptr)) begin
      rd_byte = ext;
    end else begin
      rd_byte = 8'h00;
    end
  endfunction

  assign addr_lo = strap_addr(strap_s);

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  logic load;
  logic [4:0] clr;
  logic [4:0] ev;

  always_comb begin
    nxt_q = q_ff;
    load = 1'b0;
    clr = 5'h00;
    nxt_q.wr.valid = 1'b0;
    nxt_q.scl_q = scl_s;
    nxt_q.sda_q = sda_s;
    if (start) begin
      nxt_q.st = PIA_S_ADDR;
      nxt_q.cnt = 4'h0;
      nxt_q.oe = 1'b0;
    end else if (stop) begin
      nxt_q.st = PIA_S_IDLE;
      nxt_q.oe = 1'b0;
    end else if (scl_rise) begin
      case (q_ff.st)
        PIA_S_ADDR, PIA_S_REG, PIA_S_WDATA: begin
          nxt_q.sh = {q_ff.sh[6:0], sda_s};
          nxt_q.cnt = q_ff.cnt + 4'h1;
        end
        PIA_S_RACK: nxt_q.ack_ok = ~sda_s;
        default: ;
      endcase
    end else if (scl_fall) begin
      case (q_ff.st)
        PIA_S_ADDR: begin
          if (q_ff.cnt == PIA_BITS_PER_BYTE) begin
            if (q_ff.sh[7:1] == {PIA_ADDR_HI, addr_lo}) begin
              nxt_q.st = PIA_S_AACK;
              nxt_q.oe = 1'b1;
              nxt_q.rd = q_ff.sh[0];
            end else begin
              nxt_q.st = PIA_S_IDLE;
            end
          end
        end
        PIA_S_AACK: begin
          if (q_ff.rd) begin
            load = 1'b1;
          end else begin
            nxt_q.st = PIA_S_REG;
            nxt_q.oe = 1'b0;
            nxt_q.cnt = 4'h0;
          end
        end
        PIA_S_REG: begin
          if (q_ff.cnt == PIA_BITS_PER_BYTE) begin
            nxt_q.ptr = q_ff.sh;
            nxt_q.st = PIA_S_RGACK;
            nxt_q.oe = 1'b1;
          end
        end
        PIA_S_RGACK, PIA_S_WACK: begin
          nxt_q.st = PIA_S_WDATA;
          nxt_q.oe = 1'b0;
          nxt_q.cnt = 4'h0;
        end
        PIA_S_WDATA: begin
          if (q_ff.cnt == PIA_BITS_PER_BYTE) begin
            nxt_q.st = PIA_S_WACK;
            nxt_q.oe = 1'b1;
            nxt_q.ptr = q_ff.ptr + 8'h01;
            case (q_ff.ptr)
              PIA_REG_IMASK: nxt_q.mask = pia_mask_t'(q_ff.sh[3:0]);
              PIA_REG_UNLOCK: nxt_q.page_lock_key = q_ff.sh;
              PIA_REG_PAGE: begin
                if (q_ff.page_lock_key == PIA_UNLOCK_KEY) begin
                  nxt_q.page_lock_key = PIA_KEY_RESET;
                  if (q_ff.sh <= PIA_PAGE_MAX) begin
                    nxt_q.page = q_ff.sh[1:0];
                  end
                end
              end
              PIA_REG_ISTAT: ;
              default: begin
                nxt_q.wr.valid = ~ext_rd(q_ff.page, q_ff.ptr);
                nxt_q.wr.page = q_ff.page;
                nxt_q.wr.addr = q_ff.ptr;
                nxt_q.wr.data = q_ff.sh;
              end
            endcase
          end
        end
        PIA_S_RDATA: begin
          if (q_ff.cnt == 4'h7) begin
            nxt_q.st = PIA_S_RACK;
            nxt_q.oe = 1'b0;
          end else begin
            nxt_q.cnt = q_ff.cnt + 4'h1;
            nxt_q.sh = {q_ff.sh[6:0], 1'b0};
            nxt_q.oe = ~q_ff.sh[6];
          end
        end
        PIA_S_RACK: begin
          if (q_ff.ack_ok) begin
            load = 1'b1;
          end else begin
            nxt_q.st = PIA_S_IDLE;
          end
        end
        default: ;
      endcase
    end
    // Reading status clears it, but an event arriving now still sticks.
    if (load) begin
      nxt_q.st = PIA_S_RDATA;
      nxt_q.cnt = 4'h0;
      nxt_q.sh = rd_byte(q_ff, ext_rdata);
      nxt_q.oe = ~nxt_q.sh[7];
      nxt_q.ptr = q_ff.ptr + 8'h01;
      if (q_ff.ptr == PIA_REG_ISTAT) begin
        clr = 5'h1f;
      end
    end
    // The low-time counter only runs while auto clear is enabled.
    if (|q_ff.status && q_ff.mask.irq_auto_clear_en) begin
      nxt_q.lowcnt = q_ff.lowcnt + 20'h00001;
      if (q_ff.lowcnt > 20'(AUTO_CLR_CYCLES)) begin
        clr = 5'h1f;
        nxt_q.lowcnt = '0;
      end
    end else begin
      nxt_q.lowcnt = '0;
    end
    ev = events & {{3{q_ff.mask.irq_breath_done_en}},
                   q_ff.mask.irq_short_en, q_ff.mask.irq_open_en};
    nxt_q.status = pia_status_t'((q_ff.status & ~clr) | ev);
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q_ff <= '0;
      q_ff.st <= PIA_S_IDLE;
      q_ff.page <= PIA_PAGE_LED_CONTROL;
      q_ff.page_lock_key <= PIA_KEY_RESET;
      q_ff.scl_q <= 1'b1;
      q_ff.sda_q <= 1'b1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  // The data pin is open drain: the low level is fixed, only enable moves.
  assign sda_out = 1'b0;
  assign sda_oe = q_ff.oe;
  assign rd_addr = q_ff.ptr;
  assign page_sel = q_ff.page;
  assign reg_wr = q_ff.wr;
  assign interrupt_out_n = ~|q_ff.status;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  sequence s_addr_hit;
    q_ff.st == PIA_S_ADDR && scl_fall && q_ff.cnt == PIA_BITS_PER_BYTE &&
      q_ff.sh[7:1] == {PIA_ADDR_HI, addr_lo};
  endsequence

  sequence s_data_in;
    q_ff.st == PIA_S_WDATA && scl_fall && q_ff.cnt == PIA_BITS_PER_BYTE;
  endsequence

  sequence s_page_wr;
    s_data_in ##0 q_ff.ptr == PIA_REG_PAGE;
  endsequence

  addr_ack_a: assert property (s_addr_hit |=> q_ff.oe ##1
    q_ff.oe || scl_fall) else $error("address acknowledge not driven");
  dir_bit_a: assert property (s_addr_hit |=>
    q_ff.rd == $past(q_ff.sh[0])) else $error("direction bit lost");
  ptr_incr_a: assert property (s_data_in |=>
    q_ff.ptr == $past(q_ff.ptr) + 8'h01 && q_ff.oe)
    else $error("pointer did not advance at data acknowledge");
  start_seen_a: assert property (start |=>
    q_ff.st == PIA_S_ADDR && q_ff.cnt == 4'h0) else $error("start missed");
  stop_seen_a: assert property (stop |=>
    q_ff.st == PIA_S_IDLE && !q_ff.oe) else $error("stop missed");
  sample_high_a: assert property (q_ff.st == PIA_S_REG && scl_rise |=>
    q_ff.sh[0] == $past(sda_s)) else $error("bit not sampled at rise");
  page_lock_a: assert property ($changed(q_ff.page) |->
    $past(q_ff.page_lock_key) == PIA_UNLOCK_KEY &&
    q_ff.page_lock_key == PIA_KEY_RESET)
    else $error("page changed while locked");
  page_reserved_a: assert property (s_page_wr ##0 q_ff.sh > PIA_PAGE_MAX
    |=> $stable(q_ff.page)) else $error("reserved page taken");
  auto_clear_a: assert property (q_ff.mask.irq_auto_clear_en &&
    q_ff.lowcnt > 20'(AUTO_CLR_CYCLES) && events == '0 |=>
    interrupt_out_n) else $error("auto clear failed");
  irq_gate_a: assert property (q_ff.mask == '0 && q_ff.status == '0
    |=> interrupt_out_n) else $error("masked event raised interrupt");
  reset_val_a: assert property (disable iff (1'b0) sys_rst |=>
    q_ff.page == PIA_PAGE_LED_CONTROL && q_ff.page_lock_key == 8'h00)
    else $error("bad reset state");

endmodule // pia_i2c_slave
`default_nettype wire

// >>> verilog/pia_sync.sv
// Two-stage synchroniser for inputs from outside the clock domain.
`timescale 1ns/10ps
`default_nettype none
module pia_sync
  import pia_pkg::*;
#(
  parameter int W = 4
) (
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pia_sync_t;

  pia_sync_t q_ff;
  pia_sync_t nxt_q;

  // Only the second stage is visible outside; the first may be metastable.
  always_comb begin
    nxt_q.s1 = async_in;
    nxt_q.s2 = q_ff.s1;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      q_ff <= '1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign sync_out = q_ff.s2;

endmodule // pia_sync
`default_nettype wire
